/* File: hw/irq_flags_vectors.sv */
// Pending interrupt flags, enable mask and relocatable vector table fetch.
// Assumes event inputs are one-cycle pulses on ref_clk, external pins are
// asynchronous, and the vector memory answers a read with a valid strobe.
//
// Notes on behaviour
// - Pending flags held in one 32-bit register
// - Source event sets its pending flag
// - Software writing one sets and requests interrupt
// - Software writing zero clears the flag
// - Reset loads pending register with zero
// - Register load beats simultaneous hardware set
// - Separate flags for every listed source
// - Read-zero reserved bits always read zero
// - Storable reserved bits reset zero, keep writes
// - Reset vector fixed at address zero
// - Table base is pointer shifted left eight
// - Vector location is base plus offset
// - Table base low eight bits zero
// - Fetched vector word becomes handler address
// - Interrupt offsets one to twelve as listed
// - Traps at offsets 20h to 3Fh
// - Enable bit zero masks the interrupt
`default_nettype none

module irq_flags_vectors
    import irq_vec_pkg::*;
#(
    parameter int unsigned RADDR_W = 8,
    parameter int unsigned EXT_N = 4
) (
    input wire logic ref_clk, // CPU clock, 20 MHz
    input wire logic rst, // Synchronous reset, active high
    input wire logic [RADDR_W-1:0] reg_addr, // Register byte address
    input wire logic [31:0] reg_wdata, // Write data
    input wire logic reg_wr, // Write strobe
    input wire logic reg_rd, // Read strobe
    output logic [31:0] reg_rdata, // Read data, cycle after strobe
    input wire logic [EXT_N-1:0] ext_irq_pin, // Asynchronous external requests
    input wire logic serial0_tx_evt, // Serial 0 transmit pulse
    input wire logic serial0_rx_evt, // Serial 0 receive pulse
    input wire logic timer0_evt, // Timer 0 pulse
    input wire logic timer1_evt, // Timer 1 pulse
    input wire logic dma0_evt, // DMA channel 0 pulse
    input wire logic dma1_evt, // DMA channel 1 pulse
    input wire logic cpu_int_accept, // Core can take an interrupt now
    input wire logic trap_req, // Trap instruction pulse
    input wire logic [4:0] trap_num, // Trap number
    input wire logic [31:0] vec_data, // Word read from vector memory
    input wire logic vec_data_valid, // Vector word valid pulse
    output logic cpu_irq_req, // Enabled flag pending
    output logic vec_rd, // Vector read pulse
    output logic [VADDR_W-1:0] vec_addr, // Vector location
    output logic handler_valid, // Handler address valid pulse
    output logic [VADDR_W-1:0] handler_addr, // Start of handler routine
    output logic irq_out // Block event interrupt, level
);

    // Lowest set flag index; flag order matches vector offset order
    function automatic logic [4:0] lowest_set(input logic [31:0] v);
        logic [4:0] idx;
        idx = 5'h00;
        for (int i = 31; i >= 0; i--) begin
            if (v[i]) begin
                idx = i[4:0];
            end
        end
        return idx;
    endfunction : lowest_set

    // Table base from the pointer field
    function automatic logic [VADDR_W-1:0] table_base(input logic [31:0] flags);
        logic [PTR_W-1:0] ptr;
        ptr = flags[PTR_LSB +: PTR_W];
        return {ptr, 8'h00};
    endfunction : table_base

    logic [31:0] pending_irq_flags_q;
    logic [31:0] pending_irq_flags_d;
    logic [31:0] irq_enable_mask_q;
    logic [EVT_W-1:0] evt_status_q;
    logic [EVT_W-1:0] evt_status_d;
    logic [EVT_W-1:0] evt_mask_q;
    logic [EXT_N-1:0] ext_s1_q;
    logic [EXT_N-1:0] ext_s2_q;
    logic [EXT_N-1:0] ext_s3_q;
    logic [EXT_N-1:0] ext_lvl_q;
    logic [EXT_N-1:0] ext_rise;
    logic [31:0] hw_set;
    logic [31:0] pend_en;
    logic [31:0] take_clear;
    logic [4:0] pick;
    logic [VADDR_W-1:0] vector_table_base;
    logic [7:0] irq_off;
    logic [7:0] trap_off;
    logic pend_wr;
    logic take_trap;
    logic take_irq;
    logic [EVT_W-1:0] evt_in;
    vfetch_state_t state_q;

    // Pin synchroniser; a level counts when stages two and three agree
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            ext_s1_q <= '0;
            ext_s2_q <= '0;
            ext_s3_q <= '0;
            ext_lvl_q <= '0;
        end else begin
            ext_s1_q <= ext_irq_pin;
            ext_s2_q <= ext_s1_q;
            ext_s3_q <= ext_s2_q;
            ext_lvl_q <= (ext_s2_q & ext_s3_q) | (ext_lvl_q & (ext_s2_q ^ ext_s3_q));
        end
    end

    assign ext_rise = ext_s2_q & ext_s3_q & ~ext_lvl_q;

    always_comb begin
        hw_set = 32'h0000_0000;
        hw_set[BIT_EXT0 +: EXT_N] = ext_rise;
        hw_set[BIT_TX0] = serial0_tx_evt;
        hw_set[BIT_RX0] = serial0_rx_evt;
        hw_set[BIT_TIMER0] = timer0_evt;
        hw_set[BIT_TIMER1] = timer1_evt;
        hw_set[BIT_DMA0] = dma0_evt;
        hw_set[BIT_DMA1] = dma1_evt;
    end

    // Dispatch decisions and vector arithmetic
    assign pend_wr = reg_wr && (reg_addr == OFF_PENDING[RADDR_W-1:0]);
    assign pend_en = pending_irq_flags_q & irq_enable_mask_q & SOURCE_MASK;
    assign pick = lowest_set(pend_en);
    assign take_trap = (state_q == ST_IDLE) && trap_req;
    assign take_irq = (state_q == ST_IDLE) && !trap_req && cpu_int_accept && (pend_en != 32'h0);
    assign vector_table_base = table_base(pending_irq_flags_q);
    assign irq_off = {3'h0, pick} + IRQ_OFF_STEP;
    assign trap_off = TRAP_OFF + {3'h0, trap_num};

    always_comb begin
        take_clear = 32'h0000_0000;
        if (take_irq) begin
            take_clear[pick] = 1'b1;
        end
    end

    // Pending flags: load first, else hardware sets beat the service clear
    always_comb begin
        if (pend_wr) begin
            pending_irq_flags_d = reg_wdata & STORE_MASK;
        end else begin
            pending_irq_flags_d = (pending_irq_flags_q & ~take_clear) | hw_set;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            pending_irq_flags_q <= PENDING_RESET;
        end else begin
            pending_irq_flags_q <= pending_irq_flags_d;
        end
    end

    // Enable and event mask registers
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            irq_enable_mask_q <= ENABLE_RESET;
            evt_mask_q <= EVT_RESET;
        end else if (reg_wr) begin
            if (reg_addr == OFF_ENABLE[RADDR_W-1:0]) begin
                irq_enable_mask_q <= reg_wdata & SOURCE_MASK;
            end
            if (reg_addr == OFF_EVT_MASK[RADDR_W-1:0]) begin
                evt_mask_q <= reg_wdata[EVT_W-1:0];
            end
        end
    end

    // Sticky event status; a read clears, a new event in that cycle wins
    always_comb begin
        evt_in = '0;
        evt_in[EVT_SET] = (hw_set != 32'h0) && !pend_wr;
        evt_in[EVT_LOST] = (hw_set != 32'h0) && pend_wr;
        evt_in[EVT_DISPATCH] = take_irq || take_trap;
    end

    // Next status, so the interrupt output follows a clear without lag
    always_comb begin
        if (reg_rd && (reg_addr == OFF_EVT_STATUS[RADDR_W-1:0])) begin
            evt_status_d = evt_in;
        end else begin
            evt_status_d = evt_status_q | evt_in;
        end
    end

    // Sticky status register
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            evt_status_q <= EVT_RESET;
        end else begin
            evt_status_q <= evt_status_d;
        end
    end

    // Register read data, zero for unmapped addresses
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            reg_rdata <= 32'h0000_0000;
        end else if (reg_rd) begin
            case (reg_addr)
                OFF_PENDING[RADDR_W-1:0]: reg_rdata <= pending_irq_flags_q;
                OFF_ENABLE[RADDR_W-1:0]: reg_rdata <= irq_enable_mask_q;
                OFF_EVT_STATUS[RADDR_W-1:0]: reg_rdata <= {29'h0, evt_status_q};
                OFF_EVT_MASK[RADDR_W-1:0]: reg_rdata <= {29'h0, evt_mask_q};
                default: reg_rdata <= 32'h0000_0000;
            endcase
        end else begin
            reg_rdata <= 32'h0000_0000;
        end
    end

    // Request and block interrupt outputs
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            cpu_irq_req <= 1'b0;
            irq_out <= 1'b0;
        end else begin
            cpu_irq_req <= (pending_irq_flags_d & irq_enable_mask_q & SOURCE_MASK) != 32'h0;
            irq_out <= (evt_status_d & evt_mask_q) != '0;
        end
    end

    // Vector fetch sequencer: reset vector first, then traps and interrupts
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            state_q <= ST_RESET_FETCH;
            vec_rd <= 1'b0;
            vec_addr <= RESET_VECTOR;
            handler_valid <= 1'b0;
            handler_addr <= RESET_VECTOR;
        end else begin
            vec_rd <= 1'b0;
            handler_valid <= 1'b0;
            case (state_q)
                ST_RESET_FETCH: begin
                    vec_rd <= 1'b1;
                    vec_addr <= RESET_VECTOR;
                    state_q <= ST_FETCH;
                end
                ST_IDLE: begin
                    if (take_trap) begin
                        vec_rd <= 1'b1;
                        vec_addr <= vector_table_base + {16'h0000, trap_off};
                        state_q <= ST_FETCH;
                    end else if (take_irq) begin
                        vec_rd <= 1'b1;
                        vec_addr <= vector_table_base + {16'h0000, irq_off};
                        state_q <= ST_FETCH;
                    end
                end
                ST_FETCH: begin
                    if (vec_data_valid) begin
                        handler_valid <= 1'b1;
                        handler_addr <= vec_data[VADDR_W-1:0];
                        state_q <= ST_IDLE;
                    end
                end
                default: begin
                    state_q <= ST_IDLE;
                end
            endcase
        end
    end

    // Checks
    sequence seq_irq_taken;
        (state_q == ST_IDLE) && take_irq;
    endsequence

    sequence seq_vec_back;
        (state_q == ST_FETCH) && vec_data_valid;
    endsequence

    chk_reset_clears: assert property (@(posedge ref_clk) rst |=> pending_irq_flags_q == 32'h0)
        else $error("pending flags not zero after reset");

    chk_load_wins: assert property (@(posedge ref_clk) disable iff (rst)
        (pend_wr && hw_set != 32'h0) |=> pending_irq_flags_q == ($past(reg_wdata) & STORE_MASK))
        else $error("hardware set beat a register load");

    chk_event_sets: assert property (@(posedge ref_clk) disable iff (rst)
        (!pend_wr && hw_set != 32'h0) |=> (pending_irq_flags_q & $past(hw_set)) == $past(hw_set))
        else $error("event did not set its flag");

    chk_readzero_bits: assert property (@(posedge ref_clk) disable iff (rst)
        reg_rd && reg_addr == OFF_PENDING[RADDR_W-1:0] |=> reg_rdata[7:6] == 2'b00)
        else $error("read-zero bits read as one");

    chk_sw_request: assert property (@(posedge ref_clk) disable iff (rst)
        (pend_wr && reg_wdata[BIT_TIMER0] && irq_enable_mask_q[BIT_TIMER0])
        |=> cpu_irq_req)
        else $error("software set did not request");

    chk_mask_gate: assert property (@(posedge ref_clk) disable iff (rst)
        ((pending_irq_flags_d & irq_enable_mask_q & SOURCE_MASK) == 32'h0) |=> !cpu_irq_req)
        else $error("masked flag raised a request");

    chk_reset_vector: assert property (@(posedge ref_clk) $fell(rst) |=> vec_rd && vec_addr == 24'h0)
        else $error("reset vector not fetched from zero");

    chk_lowest_first: assert property (@(posedge ref_clk) disable iff (rst)
        seq_irq_taken and pend_en[0] |=> vec_rd && vec_addr[7:0] == 8'h01)
        else $error("higher offset served before lowest");

    chk_timer_offset: assert property (@(posedge ref_clk) disable iff (rst)
        seq_irq_taken and (pend_en[8:0] == 9'h100)
        |=> vec_addr == {$past(pending_irq_flags_q[31:16]), 8'h09})
        else $error("timer 0 vector location wrong");

    chk_trap_location: assert property (@(posedge ref_clk) disable iff (rst)
        take_trap |=> vec_addr == ({$past(pending_irq_flags_q[31:16]), 8'h00} + 24'h20
        + {19'h0, $past(trap_num)}))
        else $error("trap vector location wrong");

    chk_handler_jump: assert property (@(posedge ref_clk) disable iff (rst)
        seq_vec_back |=> handler_valid && handler_addr == $past(vec_data[23:0]))
        else $error("handler address not taken from vector");

    chk_base_aligned: assert property (@(posedge ref_clk) disable iff (rst)
        (take_irq || take_trap) |=> vec_addr[VADDR_W-1:8] == $past(pending_irq_flags_q[31:16]))
        else $error("vector table base not on a boundary");

endmodule : irq_flags_vectors

`default_nettype wire

/* File: hw/irq_vec_pkg.sv */
// Constants for the CPU interrupt flag and vector table block.
// Assumes a single 20 MHz CPU clock and a plain strobe register port.
`default_nettype none

package irq_vec_pkg;

    // Register port offsets (byte addresses)
    localparam logic [7:0] OFF_PENDING = 8'h00;
    localparam logic [7:0] OFF_ENABLE = 8'h04;
    localparam logic [7:0] OFF_EVT_STATUS = 8'h08;
    localparam logic [7:0] OFF_EVT_MASK = 8'h0c;

    // Reset values
    localparam logic [31:0] PENDING_RESET = 32'h0000_0000;
    localparam logic [31:0] ENABLE_RESET = 32'h0000_0000;
    localparam logic [2:0] EVT_RESET = 3'h0;

    // Pending register field positions
    localparam int unsigned BIT_EXT0 = 0;
    localparam int unsigned BIT_TX0 = 4;
    localparam int unsigned BIT_RX0 = 5;
    localparam int unsigned BIT_TIMER0 = 8;
    localparam int unsigned BIT_TIMER1 = 9;
    localparam int unsigned BIT_DMA0 = 10;
    localparam int unsigned BIT_DMA1 = 11;
    localparam int unsigned PTR_LSB = 16;
    localparam int unsigned PTR_W = 16;
    localparam int unsigned BASE_SHIFT = 8;

    // Flag bits, storable bits (flags, spare 15:12, pointer); 7:6 read zero
    localparam logic [31:0] SOURCE_MASK = 32'h0000_0f3f;
    localparam logic [31:0] STORE_MASK = 32'hffff_ff3f;

    // Vector table layout
    localparam int unsigned VADDR_W = 24;
    localparam logic [23:0] RESET_VECTOR = 24'h00_0000;
    localparam logic [7:0] IRQ_OFF_STEP = 8'h01;
    localparam logic [7:0] TRAP_OFF = 8'h20;

    // Event status bits
    localparam int unsigned EVT_W = 3;
    localparam int unsigned EVT_SET = 0;
    localparam int unsigned EVT_LOST = 1;
    localparam int unsigned EVT_DISPATCH = 2;

    // Vector fetch sequencer
    typedef enum logic [2:0] {
        ST_RESET_FETCH = 3'b001,
        ST_IDLE = 3'b010,
        ST_FETCH = 3'b100
    } vfetch_state_t;

endpackage : irq_vec_pkg

`default_nettype wire

/* File: testbench/cpu_interrupt_flags_vectors_tb.sv */
// Self-checking bench for the interrupt flag and vector block.
// Assumes the vector memory model answers fetches.
`default_nettype none

module cpu_interrupt_flags_vectors_tb
    import irq_vec_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic [7:0] reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [3:0] ext_pin = 4'h0;
    logic [5:0] evt_v = 6'h0;
    logic accept = 1'b0;
    logic trap_req = 1'b0;
    logic [4:0] trap_num = 5'h0;
    logic [31:0] reg_rdata, vec_data, rv;
    logic vec_valid, cpu_irq_req, vec_rd, handler_valid, irq_out;
    logic [23:0] vec_addr, handler_addr;
    int miscompares = 0;
    int num_checks = 0;
    int bits[10] = '{4, 5, 8, 9, 10, 11, 0, 1, 2, 3};

    irq_flags_vectors u_irq_flags_vectors (.ref_clk(ref_clk), .rst(rst),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .ext_irq_pin(ext_pin), .serial0_tx_evt(evt_v[0]),
        .serial0_rx_evt(evt_v[1]), .timer0_evt(evt_v[2]), .timer1_evt(evt_v[3]),
        .dma0_evt(evt_v[4]), .dma1_evt(evt_v[5]), .cpu_int_accept(accept),
        .trap_req(trap_req), .trap_num(trap_num), .vec_data(vec_data),
        .vec_data_valid(vec_valid), .cpu_irq_req(cpu_irq_req), .vec_rd(vec_rd),
        .vec_addr(vec_addr), .handler_valid(handler_valid),
        .handler_addr(handler_addr), .irq_out(irq_out));

    vec_mem_model u_vec_mem_model (.ref_clk(ref_clk), .rst(rst), .vec_rd(vec_rd),
        .vec_addr(vec_addr), .vec_data(vec_data), .vec_data_valid(vec_valid));

    // Clock generator
    initial begin
        forever #25 ref_clk = ~ref_clk;
    end

    task automatic test_done();
        if (miscompares == 0 && num_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : test_done

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string msg);
        num_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, msg, seen, exp);
        end
    endtask : chk

    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask : tick

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a);
        @(posedge ref_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1 rv = reg_rdata;
    endtask : rd

    // Bounded wait on the vector read (0) or handler strobe (1)
    task automatic wait_flag(input bit which);
        int n;
        n = 0;
        // Step off the edge so a pulse launched there is seen settled
        #1;
        while (n < 100 && (which ? handler_valid : vec_rd) !== 1'b1) begin
            tick(1);
            n++;
        end
        if (n == 100) begin
            miscompares++;
            $display("CHECK FAILED at %0t: fetch timed out", $time);
            test_done();
        end
    endtask : wait_flag

    task automatic fetch(input logic [23:0] exp);
        wait_flag(1'b0);
        chk({8'h00, vec_addr}, {8'h00, exp}, "vector location");
        wait_flag(1'b1);
        chk({8'h00, handler_addr}, {8'h00, exp ^ 24'ha5a5a5}, "handler");
    endtask : fetch

    task automatic t_reset();
        fetch(RESET_VECTOR);
        rd(OFF_PENDING);
        chk(rv, PENDING_RESET, "pending reset");
        rd(OFF_ENABLE);
        chk(rv, ENABLE_RESET, "enable reset");
    endtask : t_reset

    task automatic t_storage();
        wr(OFF_PENDING, 32'hffff_ffff);
        rd(OFF_PENDING);
        chk(rv, STORE_MASK, "pending store");
        wr(OFF_PENDING, 32'h0);
        rd(OFF_PENDING);
        chk(rv, 32'h0, "pending clear");
        wr(OFF_ENABLE, 32'hffff_ffff);
        rd(OFF_ENABLE);
        chk(rv, 32'h0000_0f3f, "enable store");
        wr(OFF_ENABLE, 32'h0);
        rd(8'h40);
        chk(rv, 32'h0, "unmapped read");
    endtask : t_storage

    task automatic t_mask();
        wr(OFF_PENDING, 32'h1 << BIT_TIMER0);
        tick(3);
        chk({31'h0, cpu_irq_req}, 32'h0, "masked request");
        wr(OFF_ENABLE, 32'h1 << BIT_TIMER0);
        tick(3);
        chk({31'h0, cpu_irq_req}, 32'h1, "software request");
        wr(OFF_PENDING, 32'h0);
        tick(3);
        chk({31'h0, cpu_irq_req}, 32'h0, "request withdrawn");
        wr(OFF_ENABLE, 32'h0);
    endtask : t_mask

    task automatic t_sources();
        for (int i = 0; i < 10; i++) begin
            wr(OFF_PENDING, 32'h0);
            @(posedge ref_clk);
            if (i < 6)
                evt_v <= 6'h1 << i;
            else
                ext_pin <= 4'h1 << (i - 6);
            @(posedge ref_clk);
            evt_v <= 6'h0;
            repeat (6) @(posedge ref_clk);
            ext_pin <= 4'h0;
            rd(OFF_PENDING);
            chk(rv, 32'h1 << bits[i], "source flag");
        end
    endtask : t_sources

    task automatic t_collision();
        wr(OFF_PENDING, 32'h0);
        rd(OFF_EVT_STATUS);
        wr(OFF_EVT_MASK, 32'h1 << EVT_LOST);
        @(posedge ref_clk);
        reg_wr <= 1'b1;
        reg_addr <= OFF_PENDING;
        reg_wdata <= 32'h0;
        evt_v <= 6'h04;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
        evt_v <= 6'h0;
        tick(3);
        chk({31'h0, irq_out}, 32'h1, "lost event irq");
        rd(OFF_PENDING);
        chk(rv, 32'h0, "load wins");
        rd(OFF_EVT_STATUS);
        chk(rv & (32'h1 << EVT_LOST), 32'h1 << EVT_LOST, "lost status");
        tick(2);
        chk({31'h0, irq_out}, 32'h0, "irq cleared");
        wr(OFF_EVT_MASK, 32'h0);
    endtask : t_collision

    task automatic t_vectors();
        wr(OFF_PENDING, 32'h0123_0000);
        wr(OFF_ENABLE, 32'h0000_0f3f);
        wr(OFF_PENDING, 32'h0123_0f3f);
        @(posedge ref_clk);
        accept <= 1'b1;
        for (int i = 0; i < 10; i++)
            fetch(24'h012300 + 24'(bits[(i + 6) % 10] + 1));
        @(posedge ref_clk);
        accept <= 1'b0;
        rd(OFF_PENDING);
        chk(rv, 32'h0123_0000, "flags taken");
    endtask : t_vectors

    task automatic t_traps();
        wr(OFF_PENDING, 32'hfedc_0000);
        for (int n = 0; n < 32; n += 27) begin
            @(posedge ref_clk);
            trap_req <= 1'b1;
            trap_num <= 5'(n);
            @(posedge ref_clk);
            trap_req <= 1'b0;
            fetch(24'hfedc00 + 24'h20 + 24'(n));
        end
        @(posedge ref_clk);
        trap_req <= 1'b1;
        trap_num <= 5'h1f;
        @(posedge ref_clk);
        trap_req <= 1'b0;
        fetch(24'hfedc3f);
    endtask : t_traps

    task automatic t_midreset();
        wr(OFF_PENDING, 32'hffff_ffff);
        wr(OFF_ENABLE, 32'h0000_0f3f);
        @(posedge ref_clk);
        rst <= 1'b1;
        repeat (2) @(posedge ref_clk);
        rst <= 1'b0;
        fetch(RESET_VECTOR);
        chk({31'h0, cpu_irq_req}, 32'h0, "request after reset");
        rd(OFF_PENDING);
        chk(rv, PENDING_RESET, "pending after reset");
        rd(OFF_ENABLE);
        chk(rv, ENABLE_RESET, "enable after reset");
    endtask : t_midreset

    // Main sequence
    initial begin
        repeat (16) @(posedge ref_clk);
        rst <= 1'b0;
        t_reset();
        t_storage();
        t_mask();
        t_sources();
        t_collision();
        t_vectors();
        t_traps();
        t_midreset();
        test_done();
    end
endmodule : cpu_interrupt_flags_vectors_tb

`default_nettype wire

/* File: testbench/vec_mem_model.sv */
// Vector memory model standing behind the vector fetch port.
// Assumes one clock; answers each read LAT+1 cycles after the read is sampled.
`default_nettype none

module vec_mem_model
    import irq_vec_pkg::*;
#(
    parameter int unsigned LAT = 3
) (
    input wire logic ref_clk, // CPU clock
    input wire logic rst, // Synchronous reset, active high
    input wire logic vec_rd, // Vector read pulse
    input wire logic [VADDR_W-1:0] vec_addr, // Location read
    output logic [31:0] vec_data, // Word returned
    output logic vec_data_valid // Word valid pulse
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [7:0] cnt_q;
    logic [VADDR_W-1:0] addr_q;
    logic busy_q;

    // Handler word is the location scrambled; data toggles while idle
    always_ff @(posedge ref_clk) begin
        vec_data_valid <= 1'b0;
        vec_data <= ~vec_data;
        if (rst) begin
            busy_q <= 1'b0;
            cnt_q <= 8'h00;
            vec_data <= 32'h0000_0000;
        end else if (vec_rd) begin
            busy_q <= 1'b1;
            cnt_q <= 8'h00;
            addr_q <= vec_addr;
        end else if (busy_q) begin
            cnt_q <= cnt_q + 8'h01;
            if (cnt_q == 8'(LAT)) begin
                busy_q <= 1'b0;
                vec_data_valid <= 1'b1;
                vec_data <= {8'h00, addr_q ^ 24'ha5a5a5};
            end
        end
    end
endmodule : vec_mem_model

`default_nettype wire
